// file: verilog/lcd_pkg.sv
// Shared constants and types for the segment display driver.
package lcd_pkg;
  localparam logic [7:0] mem_base_addr = 8'h80;
  localparam logic [7:0] mem_last_addr = 8'haf;
  localparam logic [7:0] ctrl_addr     = 8'hde;
  localparam int mem_words     = 48;
  localparam int mem_bits      = 192;
  localparam int seg_count     = 32;
  localparam int com_count     = 4;
  localparam int map_width     = 1024;
  localparam int on_bit        = 0;
  localparam int duty_lo_bit   = 2;
  localparam logic       display_on_reset = 1'b0;
  localparam logic [1:0] duty_reset       = 2'h0;
  localparam int slow_osc_hz      = 32768;
  localparam int frame_div_long   = 1024;
  localparam int frame_div_third  = 768;
  localparam int slot_ticks_third = frame_div_third / 3;
  localparam logic [15:0] static_pair_reset = 16'h0000;

  typedef enum logic [1:0] {
    duty_quarter = 2'b00,
    duty_third   = 2'b01,
    duty_half    = 2'b10,
    duty_whole   = 2'b11
  } duty_type;

  typedef enum logic [1:0] {
    level_vss = 2'b00,
    level_vc1 = 2'b01,
    level_vc2 = 2'b10,
    level_vc3 = 2'b11
  } level_type;

  function automatic logic [1:0] last_com(input logic [1:0] duty);
    last_com = 2'h3 - duty;
  endfunction

  // Index of the last oscillator tick of one backplane slot; a whole-duty slot is 1024 ticks.
  function automatic logic [9:0] slot_last(input logic [1:0] duty);
    case (duty)
      duty_quarter: slot_last = 10'(frame_div_long / 4 - 1);
      duty_third:   slot_last = 10'(slot_ticks_third - 1);
      duty_half:    slot_last = 10'(frame_div_long / 2 - 1);
      default:      slot_last = 10'(frame_div_long - 1);
    endcase
  endfunction

  function automatic logic [10:0] frame_ticks(input logic [1:0] duty);
    frame_ticks = (duty == duty_third) ? 11'(frame_div_third) : 11'(frame_div_long);
  endfunction

  // Entry (seg*4+com) holds the memory bit index shown at that segment position.
  function automatic logic [map_width-1:0] default_map();
    logic [map_width-1:0] m;
    m = '0;
    for (int s = 0; s < seg_count; s++) begin
      for (int c = 0; c < com_count; c++) begin
        m[(s*com_count+c)*8 +: 8] = 8'(c*seg_count + s);
      end
    end
    return m;
  endfunction

  function automatic logic [mem_bits-1:0] first_backplane_line_mask(input logic [map_width-1:0] map);
    logic [mem_bits-1:0] m;
    m = '0;
    for (int s = 0; s < seg_count; s++) begin
      m[map[s*com_count*8 +: 8]] = 1'b1;
    end
    return m;
  endfunction
endpackage

// file: verilog/lcd_frame_timer.sv
// Frame timing: slow oscillator sampling, slot sequencing and frame polarity.
`timescale 1ns/1ps
module lcd_frame_timer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       osc_pin,
  input  wire logic       enable,
  input  wire logic [1:0] duty,
  output logic      [1:0] slot,
  output logic            polarity,
  output logic            frame_start,
  output logic            tick
);
  logic       sync1_reg;
  logic       sync2_reg;
  logic       sync3_reg;
  logic       osc_level_reg;
  logic [9:0] tick_cnt_reg;
  logic [1:0] slot_reg;
  logic       polarity_reg;
  logic       frame_start_reg;

  always_ff @(posedge clk) begin
    sync1_reg <= osc_pin;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osc_level_reg <= 1'b0;
    end else if (sync2_reg == sync3_reg) begin
      osc_level_reg <= sync2_reg;
    end
  end

  assign tick = sync2_reg && sync3_reg && !osc_level_reg;

  // Each backplane slot lasts the same number of oscillator periods.
  always_ff @(posedge clk) begin
    if (rst || !enable) begin
      tick_cnt_reg    <= 10'h000;
      slot_reg        <= 2'h0;
      polarity_reg    <= 1'b0;
      frame_start_reg <= 1'b0;
    end else begin
      frame_start_reg <= 1'b0;
      if (tick) begin
        if (tick_cnt_reg >= lcd_pkg::slot_last(duty)) begin
          tick_cnt_reg <= 10'h000;
          if (slot_reg >= lcd_pkg::last_com(duty)) begin
            slot_reg        <= 2'h0;
            polarity_reg    <= !polarity_reg;
            frame_start_reg <= 1'b1;
          end else begin
            slot_reg <= slot_reg + 2'h1;
          end
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 10'h001;
        end
      end
    end
  end

  assign slot        = slot_reg;
  assign polarity    = polarity_reg;
  assign frame_start = frame_start_reg;
endmodule // lcd_frame_timer

// file: verilog/lcd_drive_levels.sv
// Four-level backplane and electrode waveform generation.
`timescale 1ns/1ps
module lcd_drive_levels (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        display_on,
  input  wire logic [1:0]  slot,
  input  wire logic        polarity,
  input  wire logic [31:0] lit,
  output logic      [7:0]  com_level,
  output logic      [63:0] seg_level
);
  logic [7:0]  com_level_reg;
  logic [63:0] seg_level_reg;

  // Selected pairs see three steps; all other pairs see one step.
  always_ff @(posedge clk) begin
    if (rst || !display_on) begin
      com_level_reg <= {4{lcd_pkg::level_vc1}};
      seg_level_reg <= {32{lcd_pkg::level_vc1}};
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (slot == 2'(c)) begin
          com_level_reg[c*2 +: 2] <= polarity ? lcd_pkg::level_vss : lcd_pkg::level_vc3;
        end else begin
          com_level_reg[c*2 +: 2] <= polarity ? lcd_pkg::level_vc2 : lcd_pkg::level_vc1;
        end
      end
      for (int s = 0; s < 32; s++) begin
        if (lit[s]) begin
          seg_level_reg[s*2 +: 2] <= polarity ? lcd_pkg::level_vc3 : lcd_pkg::level_vss;
        end else begin
          seg_level_reg[s*2 +: 2] <= polarity ? lcd_pkg::level_vc1 : lcd_pkg::level_vc2;
        end
      end
    end
  end

  assign com_level = com_level_reg;
  assign seg_level = seg_level_reg;
endmodule // lcd_drive_levels

// file: verilog/lcd_segment_driver.sv
// Segment display driver top: registers, display memory, decoder and outputs.
`timescale 1ns/1ps
// Contract
// - Four backplane lines, thirty-two electrode outputs.
// - Duty field selects quarter, third, half, whole.
// - Backplane lines used follow the duty.
// - Frame is 1024 oscillator periods, 768 at third.
// - Four-level multiplexed drive, internally generated levels.
// - Off after reset; off blanks all at level one; static_out and static_oe still follow the first-slot bits.
// - Display bit reads back; off keeps memory.
// - Control nibble: on, zero, two duty bits.
// - Forty-eight write-only nibbles, reads return nothing.
// - Memory one lights segment, zero darkens.
// - Fixed decoder maps any bit anywhere.
// - Electrode pairs fixed as multiplexed or static.
// - Static output drives first-slot bit, push-pull/open-drain.
// - Reset sets first-slot bits; static outputs high.
module lcd_segment_driver #(
  parameter logic [lcd_pkg::map_width-1:0] seg_map      = lcd_pkg::default_map(),
  parameter logic [15:0]                   static_pairs = lcd_pkg::static_pair_reset,
  parameter logic [31:0]                   open_drain   = 32'h0000_0000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        osc_pin,
  input  wire logic [7:0]  addr,
  input  wire logic [3:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [3:0]  rdata,
  output logic      [7:0]  backplane_lines,
  output logic      [63:0] electrode_outputs,
  output logic      [31:0] static_out,
  output logic      [31:0] static_oe,
  output logic      [31:0] static_mode
);
  logic                         display_on_bit_reg;
  logic [1:0]                   duty_reg;
  logic [3:0]                   mem_reg [lcd_pkg::mem_words];
  logic [lcd_pkg::mem_bits-1:0] mem_flat;
  logic [3:0]                   rdata_reg;
  logic [31:0]                  static_out_reg;
  logic [31:0]                  static_oe_reg;
  logic [31:0]                  lit_now;
  logic [31:0]                  first_slot_bits;
  logic [31:0]                  pair_static;
  logic [1:0]                   slot;
  logic                         polarity;
  logic                         frame_start;
  logic                         tick;

  // Control nibble: bit 0 display on, bit 1 constant zero, bits 3..2 duty.
  always_ff @(posedge clk) begin
    if (rst) begin
      display_on_bit_reg <= lcd_pkg::display_on_reset;
      duty_reg           <= lcd_pkg::duty_reset;
    end else if (wr && addr == lcd_pkg::ctrl_addr) begin
      display_on_bit_reg <= wdata[lcd_pkg::on_bit];
      duty_reg           <= wdata[lcd_pkg::duty_lo_bit +: 2];
    end
  end

  // Display memory; turning the display off does not touch it.
  localparam logic [lcd_pkg::mem_bits-1:0] mem_reset_image = lcd_pkg::first_backplane_line_mask(seg_map);
  always_ff @(posedge clk) begin
    for (int w = 0; w < lcd_pkg::mem_words; w++) begin
      if (rst) begin
        mem_reg[w] <= mem_reset_image[w*4 +: 4];
      end else if (wr && addr == lcd_pkg::mem_base_addr + 8'(w)) begin
        mem_reg[w] <= wdata;
      end
    end
  end

  // Flat bit view of the memory, indexed by the decoder map.
  always_comb begin
    for (int w = 0; w < lcd_pkg::mem_words; w++) begin
      mem_flat[w*4 +: 4] = mem_reg[w];
    end
  end

  // Read data stand for exactly one cycle; memory and unmapped reads give zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 4'h0;
    end else if (rd && addr == lcd_pkg::ctrl_addr) begin
      rdata_reg <= {duty_reg, 1'b0, display_on_bit_reg};
    end else begin
      rdata_reg <= 4'h0;
    end
  end

  // Decoder: every segment position picks its bit through the fixed map.
  always_comb begin
    for (int s = 0; s < 32; s++) begin
      lit_now[s]         = mem_flat[seg_map[(s*4 + int'(slot))*8 +: 8]];
      first_slot_bits[s] = mem_flat[seg_map[s*4*8 +: 8]];
      pair_static[s]     = static_pairs[s/2];
    end
  end

  // Static electrodes drive logic levels; open-drain ones only pull low.
  always_ff @(posedge clk) begin
    if (rst) begin
      static_out_reg <= 32'h0000_0000;
      static_oe_reg  <= 32'h0000_0000;
    end else begin
      static_out_reg <= first_slot_bits & pair_static;
      static_oe_reg  <= pair_static & ~(open_drain & first_slot_bits);
    end
  end

  lcd_frame_timer u_timer (
    .clk         (clk),
    .rst         (rst),
    .osc_pin     (osc_pin),
    .enable      (display_on_bit_reg),
    .duty        (duty_reg),
    .slot        (slot),
    .polarity    (polarity),
    .frame_start (frame_start),
    .tick        (tick)
  );

  lcd_drive_levels u_levels (
    .clk        (clk),
    .rst        (rst),
    .display_on (display_on_bit_reg),
    .slot       (slot),
    .polarity   (polarity),
    .lit        (lit_now),
    .com_level  (backplane_lines),
    .seg_level  (electrode_outputs)
  );

  assign rdata       = rdata_reg;
  assign static_out  = static_out_reg;
  assign static_oe   = static_oe_reg;
  assign static_mode = pair_static;

  // Helper: oscillator ticks counted since the last frame start.
  logic [10:0] frame_tick_cnt;
  logic        frame_clean;
  always_ff @(posedge clk) begin
    if (rst || !display_on_bit_reg) begin
      frame_tick_cnt <= 11'h000;
      frame_clean    <= 1'b0;
    end else if (frame_start) begin
      frame_tick_cnt <= tick ? 11'h001 : 11'h000;
      frame_clean    <= 1'b1;
    end else begin
      frame_tick_cnt <= frame_tick_cnt + (tick ? 11'h001 : 11'h000);
      if (wr && addr == lcd_pkg::ctrl_addr) begin
        frame_clean <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ctrl_readback;
    rd && addr == lcd_pkg::ctrl_addr |=> rdata == {$past(duty_reg), 1'b0, $past(display_on_bit_reg)};
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

  property p_write_on;
    wr && addr == lcd_pkg::ctrl_addr ##1 rd && addr == lcd_pkg::ctrl_addr
      |=> rdata[0] == $past(wdata[0], 2) && rdata[3:2] == $past(wdata[3:2], 2);
  endproperty
  a_write_on: assert property (p_write_on) else $error("display bit not as written");

  property p_mem_read_zero;
    rd && addr >= lcd_pkg::mem_base_addr && addr <= lcd_pkg::mem_last_addr |=> rdata == 4'h0;
  endproperty
  a_mem_read_zero: assert property (p_mem_read_zero) else $error("memory read not zero");

  property p_off_blank;
    !display_on_bit_reg |=> backplane_lines == 8'h55 && electrode_outputs == {32{2'b01}};
  endproperty
  a_off_blank: assert property (p_off_blank) else $error("display off not blanked");

  property p_slot_range;
    display_on_bit_reg && !(wr && addr == lcd_pkg::ctrl_addr) ##1 $stable(duty_reg)
      |-> slot <= lcd_pkg::last_com(duty_reg) || $past(slot) > lcd_pkg::last_com(duty_reg);
  endproperty
  a_slot_range: assert property (p_slot_range) else $error("unused backplane selected");

  property p_frame_len;
    frame_start && frame_clean && $stable(duty_reg) |-> frame_tick_cnt == lcd_pkg::frame_ticks(duty_reg);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

  property p_polarity_flip;
    frame_start |-> polarity != $past(polarity);
  endproperty
  a_polarity_flip: assert property (p_polarity_flip) else $error("polarity did not alternate");

  property p_lit_seg0;
    display_on_bit_reg && lit_now[0] |=> electrode_outputs[1:0] ==
      ($past(polarity) ? lcd_pkg::level_vc3 : lcd_pkg::level_vss);
  endproperty
  a_lit_seg0: assert property (p_lit_seg0) else $error("lit segment level wrong");

  property p_static_follow;
    !rst ##1 1'b1 |-> static_out == ($past(first_slot_bits) & $past(pair_static));
  endproperty
  a_static_follow: assert property (p_static_follow) else $error("static output wrong");

  property p_reset_static;
    $fell(rst) |=> static_out == pair_static;
  endproperty
  a_reset_static: assert property (p_reset_static) else $error("static not high after reset");

  property p_mem_kept;
    wr && addr == lcd_pkg::ctrl_addr && !wdata[0] |=> $stable(mem_flat);
  endproperty
  a_mem_kept: assert property (p_mem_kept) else $error("memory changed on display off");

  property p_duty_write;
    wr && addr == lcd_pkg::ctrl_addr |=> duty_reg == $past(wdata[3:2]);
  endproperty
  a_duty_write: assert property (p_duty_write) else $error("duty field not as written");

  property p_mem_write;
    wr && addr == lcd_pkg::mem_base_addr |=> mem_reg[0] == $past(wdata);
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("memory word not written");

  property p_sel_first_backplane_line;
    display_on_bit_reg && slot == 2'h0 |=> backplane_lines[1:0] ==
      ($past(polarity) ? lcd_pkg::level_vss : lcd_pkg::level_vc3);
  endproperty
  a_sel_first_backplane_line: assert property (p_sel_first_backplane_line) else $error("selected backplane level wrong");

  property p_unlit_seg0;
    display_on_bit_reg && !lit_now[0] |=> electrode_outputs[1:0] ==
      ($past(polarity) ? lcd_pkg::level_vc1 : lcd_pkg::level_vc2);
  endproperty
  a_unlit_seg0: assert property (p_unlit_seg0) else $error("dark segment level wrong");

  property p_reset_off;
    $fell(rst) |-> !display_on_bit_reg && duty_reg == lcd_pkg::duty_reset;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("control not cleared by reset");

  c_display_on: cover property (display_on_bit_reg && frame_start);
  c_third_frame: cover property (duty_reg == lcd_pkg::duty_third && frame_start && frame_clean);
  c_whole_duty: cover property (duty_reg == lcd_pkg::duty_whole && frame_start);
  c_mem_write: cover property (wr && addr == lcd_pkg::mem_last_addr);
  c_display_off: cover property (display_on_bit_reg && wr && addr == lcd_pkg::ctrl_addr && !wdata[0]);
endmodule // lcd_segment_driver

// file: test/lcd_panel_model.sv
// Passive multiplexed glass panel that records which segments were driven lit.
`timescale 1ns/1ps
module lcd_panel_model (
  input  wire logic         clk,
  input  wire logic         clear,
  input  wire logic [7:0]   com_lv,
  input  wire logic [63:0]  seg_lv,
  output logic      [127:0] lit
);
  // A segment only turns on when it sees the full swing between ground and the top level.
  always_ff @(posedge clk) begin
    for (int s = 0; s < 32; s++) begin
      for (int c = 0; c < 4; c++) begin
        if (clear) begin
          lit[s*4+c] <= 1'b0;
        end else if ({com_lv[c*2 +: 2], seg_lv[s*2 +: 2]} inside {4'hc, 4'h3}) begin
          lit[s*4+c] <= 1'b1;
        end
      end
    end
  end
endmodule // lcd_panel_model

// file: test/testbench.sv
// Self-checking bench for the segment display driver.
`timescale 1ns/1ps
module testbench;
  logic         clk;
  logic         rst;
  logic         osc_pin;
  logic [7:0]   addr;
  logic [3:0]   wdata;
  logic         wr;
  logic         rd;
  logic         clr;
  logic [3:0]   rdata;
  logic [7:0]   backplane_lines;
  logic [63:0]  electrode_outputs;
  logic [31:0]  static_out;
  logic [31:0]  static_oe;
  logic [31:0]  static_mode;
  logic [127:0] lit;
  logic [3:0]   mem [48];
  logic [3:0]   v;
  int           n_mismatch = 0;
  int           n_compared = 0;
  int           cyc = 0;

  lcd_segment_driver #(.static_pairs(16'h0001), .open_drain(32'h0000_0002)) dut (
    .clk(clk), .rst(rst), .osc_pin(osc_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .backplane_lines(backplane_lines), .electrode_outputs(electrode_outputs),
    .static_out(static_out), .static_oe(static_oe), .static_mode(static_mode));

  lcd_panel_model panel (.clk(clk), .clear(clr), .com_lv(backplane_lines),
    .seg_lv(electrode_outputs), .lit(lit));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // The crystal is sped up to one period per eight system clocks.
  initial begin
    osc_pin = 1'b0;
    forever #20 osc_pin = ~osc_pin;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [127:0] e, input logic [127:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [3:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Write, then read in the very next cycle with no idle cycle between the strobes.
  task automatic wr_rd(input logic [7:0] a, input logic [3:0] d, output logic [3:0] q);
    wr_reg(a, d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask

  // Widest-division duty whose backplane count still covers the panel's segments.
  function automatic logic [1:0] duty_for(input int segs);
    if (segs <= 32) return 2'h3;
    if (segs <= 64) return 2'h2;
    if (segs <= 96) return 2'h1;
    return 2'h0;
  endfunction

  function automatic logic [127:0] exp_lit(input logic [1:0] duty);
    logic [127:0] e;
    for (int s = 0; s < 32; s++) begin
      for (int c = 0; c < 4; c++) begin
        e[s*4+c] = (c <= 3 - duty) && mem[(c*32+s)/4][(c*32+s)%4];
      end
    end
    return e;
  endfunction

  // Returns at the first cycle where the first backplane line enters a selected level.
  task automatic wait_sel(output logic [1:0] lv);
    logic [1:0] p;
    p = backplane_lines[1:0];
    for (int i = 0; i < 10000; i++) begin
      @(posedge clk);
      #1;
      if (backplane_lines[1:0] !== p && backplane_lines[1:0] inside {2'h0, 2'h3}) break;
      p = backplane_lines[1:0];
    end
    lv = backplane_lines[1:0];
  endtask

  task automatic frame_check(input logic [1:0] duty);
    int         t0;
    int         len;
    logic [1:0] a;
    logic [1:0] b;
    len = (duty == 2'h1) ? 768 * 8 : 1024 * 8;
    wait_sel(a);
    t0 = cyc;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_sel(b);
    chk("frame_len", 1'b1, (cyc - t0 > len - 8) && (cyc - t0 <= len));
    chk("polarity", a ^ 2'h3, b);
    chk("lit", exp_lit(duty), lit);
    // The second frame starts on a tick, so its length is exact.
    t0 = cyc;
    wait_sel(a);
    chk("frame_len_2", len, cyc - t0);
    chk("polarity_2", b ^ 2'h3, a);
  endtask

  task automatic blank_check();
    repeat (3) @(posedge clk);
    #1;
    chk("blank_com", 8'h55, backplane_lines);
    chk("blank_seg", {32{2'b01}}, electrode_outputs);
  endtask

  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 4'h0;
    wr = 1'b0;
    rd = 1'b0;
    clr = 1'b0;
    void'($urandom(49817));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("static_mode", 32'h3, static_mode);
    chk("static_reset", 3'b011, {static_oe[1:0], static_out[0]});
    blank_check();
    rd_reg(lcd_pkg::ctrl_addr, v);
    chk("ctrl_reset", 4'h0, v);
    for (int w = 0; w < 48; w++) begin
      mem[w] = 4'($urandom);
      wr_reg(lcd_pkg::mem_base_addr + 8'(w), mem[w]);
    end
    rd_reg(lcd_pkg::mem_base_addr, v);
    chk("mem_read", 4'h0, v);
    rd_reg(lcd_pkg::mem_last_addr, v);
    chk("mem_read_last", 4'h0, v);
    rd_reg(8'h7f, v);
    chk("unmapped_read", 4'h0, v);
    #1;
    chk("static_data", {~mem[0][1], 1'b1, mem[0][0]}, {static_oe[1:0], static_out[0]});
    for (int d = 0; d < 4; d++) begin
      wr_reg(lcd_pkg::ctrl_addr, {duty_for(128 - 32 * d), 2'b11});
      frame_check(2'(d));
      rd_reg(lcd_pkg::ctrl_addr, v);
      chk("ctrl", {2'(d), 2'b01}, v);
      wr_rd(lcd_pkg::ctrl_addr, {2'(d), 2'b10}, v);
      chk("ctrl_off", {2'(d), 2'b00}, v);
      blank_check();
    end
    // Static whole-duty pattern with every slot-0 segment lit, as used for crystal trimming.
    for (int w = 0; w < 8; w++) begin
      mem[w] = 4'hf;
      wr_reg(lcd_pkg::mem_base_addr + 8'(w), 4'hf);
    end
    wr_reg(lcd_pkg::ctrl_addr, 4'hd);
    frame_check(2'h3);
    results();
  end
endmodule // testbench
